// ### rtl/sstx_defines.svh
`ifndef SSTX_DEFINES_SVH
`define SSTX_DEFINES_SVH

// ****************************************
// register indices, byte address is index * 4
// ****************************************
`define SSTX_IDX_CH6        8'h23
`define SSTX_IDX_CH7        8'h24
`define SSTX_IDX_CH8        8'h25
`define SSTX_IDX_CTRL       8'h30

// ****************************************
// reset values
// ****************************************
`define SSTX_RST_CH6        8'h05
`define SSTX_RST_CH7        8'h06
`define SSTX_RST_CH8        8'h07
`define SSTX_RST_CTRL       8'h00

// ****************************************
// field positions
// ****************************************
`define SSTX_SLOT_LSB       0
`define SSTX_SLOT_MSB       4
`define SSTX_SRC_LSB        5
`define SSTX_SRC_MSB        6
`define SSTX_CH8_SRC_BIT    5
`define SSTX_CTRL_FMT_BIT   0
`define SSTX_CTRL_WL_LSB    1
`define SSTX_CTRL_WL_MSB    2

// ****************************************
// source codes and masks
// ****************************************
`define SSTX_SRC_HIZ        2'h0
`define SSTX_SRC_LOOP       2'h1
`define SSTX_SRC_ECHO       2'h2
`define SSTX_MASK_CH67      8'h7f
`define SSTX_MASK_CH8       8'h3f
`define SSTX_MASK_CTRL      8'h07
`define SSTX_HALF_SLOTS     5'h10

// ****************************************
// last bit index per word length, response codes
// ****************************************
`define SSTX_LAST_WL16      5'h0f
`define SSTX_LAST_WL20      5'h13
`define SSTX_LAST_WL24      5'h17
`define SSTX_LAST_WL32      5'h1f
`define SSTX_RSP_OK         2'h0
`define SSTX_RSP_ERR        2'h2

`endif

// ### rtl/sstx_pkg.sv
package sstx_pkg;

    // link side sample inputs
    typedef struct packed {
        logic [31:0] loop_ch2;
        logic [31:0] echo_ch2;
        logic [15:0] first_echo_half_word;
        logic [15:0] second_echo_half_word;
        logic [31:0] inter_chip_link_data;
    } sstx_samples_s;

    // serial data pin pair
    typedef struct packed {
        logic dout;
        logic dout_oe;
    } sstx_pin_s;

    typedef enum logic [1:0] {
        SSTX_WL16 = 2'b00,
        SSTX_WL20 = 2'b01,
        SSTX_WL24 = 2'b10,
        SSTX_WL32 = 2'b11
    } sstx_wlen_e;

    typedef enum logic [1:0] {
        SSTX_BUS_IDLE = 2'b00,
        SSTX_BUS_ACK  = 2'b01
    } sstx_bus_e;

endpackage

// ### rtl/sstx_slot_map.sv
`timescale 1ns/10ps
`include "sstx_defines.svh"
// Functional notes
// - source select zero on channels 6, 7, 8 leaves the line released
// - channel 6 code 1 loopback input 2, code 2 echo ch2, 3 reserved
// - channel 7 code 2 sends two half-word echo samples concatenated
// - channel 8 bit 5 one sends inter-chip link data, zero releases
// - five-bit slot field bits 4-0 selects tdm slot 0 to 31
// - i2s/lj: values 0-15 left half slots, 16-31 right half slots
// - reset values 0x05, 0x06, 0x07: released, slots 5, 6, 7
module sstx_slot_map (
    // system
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    // avalon-mm slave
    input  wire logic [9:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [3:0]           avs_byteenable_i,
    input  wire logic [31:0]          avs_writedata_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    output logic      [1:0]           avs_response_o,
    // link clock domain
    input  wire logic                 link_bclk_i,
    input  wire logic                 link_rst_n_i,
    input  wire logic                 link_fsync_i,
    input  wire sstx_pkg::sstx_samples_s link_samples_i,
    // serial data pin
    output logic                      link_dout_o,
    output logic                      link_dout_oe_o
);
    import sstx_pkg::*;

    // ****************************************
    // register file, system domain
    // ****************************************
    logic [7:0]  cfg_reg [3];
    logic [7:0]  ctrl;
    sstx_bus_e   bus_state;
    logic [7:0]  idx;
    logic        hit;
    logic [1:0]  sel;

    assign idx = avs_address_i[9:2];

    // decode index to register number
    function automatic logic [2:0] decode(input logic [7:0] a);
        unique case (a)
            `SSTX_IDX_CH6:  decode = 3'h0;
            `SSTX_IDX_CH7:  decode = 3'h1;
            `SSTX_IDX_CH8:  decode = 3'h2;
            `SSTX_IDX_CTRL: decode = 3'h3;
            default:        decode = 3'h4;
        endcase
    endfunction

    logic [2:0]  dec;
    logic        req;
    logic        wr_take;
    logic        rd_load;

    // index decode shared by write and read paths
    assign dec     = decode(idx);
    assign hit     = ~dec[2];
    assign sel     = dec[1:0];
    assign req     = avs_read_i || avs_write_i;
    assign wr_take = (bus_state == SSTX_BUS_ACK) && avs_write_i && hit && avs_byteenable_i[0];
    assign rd_load = (bus_state == SSTX_BUS_IDLE) && req;

    // register contents by register number
    function automatic logic [7:0] reg_value(input logic [1:0] n);
        unique case (n)
            2'h0: reg_value = cfg_reg[0];
            2'h1: reg_value = cfg_reg[1];
            2'h2: reg_value = cfg_reg[2];
            2'h3: reg_value = ctrl;
        endcase
    endfunction

    // one wait cycle, answer in second cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_state <= SSTX_BUS_IDLE;
        end else begin
            unique case (bus_state)
                SSTX_BUS_IDLE: begin
                    if (req) begin
                        bus_state <= SSTX_BUS_ACK;
                    end
                end
                SSTX_BUS_ACK: begin
                    bus_state <= SSTX_BUS_IDLE;
                end
                default: begin
                    bus_state <= SSTX_BUS_IDLE;
                end
            endcase
        end
    end

    assign avs_waitrequest_o = req && (bus_state != SSTX_BUS_ACK);

    // write of configuration, reserved bits masked
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_reg[0] <= `SSTX_RST_CH6;
            cfg_reg[1] <= `SSTX_RST_CH7;
            cfg_reg[2] <= `SSTX_RST_CH8;
            ctrl       <= `SSTX_RST_CTRL;
        end else if (wr_take) begin
            unique case (sel)
                2'h0: cfg_reg[0] <= avs_writedata_i[7:0] & `SSTX_MASK_CH67;
                2'h1: cfg_reg[1] <= avs_writedata_i[7:0] & `SSTX_MASK_CH67;
                2'h2: cfg_reg[2] <= avs_writedata_i[7:0] & `SSTX_MASK_CH8;
                2'h3: ctrl       <= avs_writedata_i[7:0] & `SSTX_MASK_CTRL;
            endcase
        end
    end

    // ****************************************
    // read path, loaded in the wait cycle
    // ****************************************
    // response code, slave error on unmapped index
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_response_o <= `SSTX_RSP_OK;
        end else if (rd_load) begin
            avs_response_o <= hit ? `SSTX_RSP_OK : `SSTX_RSP_ERR;
        end
    end

    // read data, unmapped reads and writes give zero
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (rd_load && avs_read_i && hit) begin
            avs_readdata_o <= {24'h00_0000, reg_value(sel)};
        end else if (rd_load) begin
            avs_readdata_o <= 32'h0000_0000;
        end
    end

    // ****************************************
    // crossing into link domain
    // ****************************************
    // config is quasi-static: three-stage sync, update when last two agree
    logic [31:0] cfg_flat;
    logic [31:0] cfg_s1;
    logic [31:0] cfg_s2;
    logic [31:0] cfg_s3;
    logic [31:0] cfg_link;

    assign cfg_flat = {ctrl, cfg_reg[2], cfg_reg[1], cfg_reg[0]};

    always_ff @(posedge link_bclk_i or negedge link_rst_n_i) begin
        if (!link_rst_n_i) begin
            cfg_s1   <= {`SSTX_RST_CTRL, `SSTX_RST_CH8, `SSTX_RST_CH7, `SSTX_RST_CH6};
            cfg_s2   <= {`SSTX_RST_CTRL, `SSTX_RST_CH8, `SSTX_RST_CH7, `SSTX_RST_CH6};
            cfg_s3   <= {`SSTX_RST_CTRL, `SSTX_RST_CH8, `SSTX_RST_CH7, `SSTX_RST_CH6};
            cfg_link <= {`SSTX_RST_CTRL, `SSTX_RST_CH8, `SSTX_RST_CH7, `SSTX_RST_CH6};
        end else begin
            cfg_s1 <= cfg_flat;
            cfg_s2 <= cfg_s1;
            cfg_s3 <= cfg_s2;
            if (cfg_s2 == cfg_s3) begin
                cfg_link <= cfg_s3;
            end
        end
    end

    // ****************************************
    // slot timing, link domain
    // ****************************************
    logic        fsync_d;
    logic        fsync_rise;
    logic        fsync_fall;
    logic [4:0]  slot_cnt;
    logic [4:0]  bit_cnt;
    logic        right_half;
    logic [4:0]  wl_last;
    logic        i2s_mode;
    sstx_wlen_e  wlen;
    logic [1:0]  src_ch6;
    logic [1:0]  src_ch7;
    logic        src_ch8;

    // link side view of control and source fields
    assign i2s_mode = cfg_link[24 + `SSTX_CTRL_FMT_BIT];
    assign wlen     = sstx_wlen_e'(cfg_link[24 + `SSTX_CTRL_WL_MSB : 24 + `SSTX_CTRL_WL_LSB]);
    assign src_ch6  = cfg_link[`SSTX_SRC_MSB : `SSTX_SRC_LSB];
    assign src_ch7  = cfg_link[8 + `SSTX_SRC_MSB : 8 + `SSTX_SRC_LSB];
    assign src_ch8  = cfg_link[16 + `SSTX_CH8_SRC_BIT];

    // word length as last bit index
    always_comb begin
        unique case (wlen)
            SSTX_WL16: wl_last = `SSTX_LAST_WL16;
            SSTX_WL20: wl_last = `SSTX_LAST_WL20;
            SSTX_WL24: wl_last = `SSTX_LAST_WL24;
            SSTX_WL32: wl_last = `SSTX_LAST_WL32;
        endcase
    end

    // delayed frame sync for edge detection
    always_ff @(posedge link_bclk_i or negedge link_rst_n_i) begin
        if (!link_rst_n_i) begin
            fsync_d <= 1'b0;
        end else begin
            fsync_d <= link_fsync_i;
        end
    end

    // rise starts a frame, fall starts the right half
    assign fsync_rise = link_fsync_i && !fsync_d;
    assign fsync_fall = !link_fsync_i && fsync_d;

    // bit and slot counters, restarted on frame edges
    always_ff @(posedge link_bclk_i or negedge link_rst_n_i) begin
        if (!link_rst_n_i) begin
            slot_cnt <= 5'h00;
            bit_cnt  <= 5'h00;
        end else if (fsync_rise || (i2s_mode && fsync_fall)) begin
            slot_cnt <= 5'h00;
            bit_cnt  <= 5'h00;
        end else if (bit_cnt == wl_last) begin
            bit_cnt  <= 5'h00;
            slot_cnt <= slot_cnt + 5'h01;
        end else begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // half flag for i2s and left-justified framing
    always_ff @(posedge link_bclk_i or negedge link_rst_n_i) begin
        if (!link_rst_n_i) begin
            right_half <= 1'b0;
        end else if (fsync_rise) begin
            right_half <= 1'b0;
        end else if (i2s_mode && fsync_fall) begin
            right_half <= 1'b1;
        end
    end

    // ****************************************
    // per-channel source and slot match
    // ****************************************
    logic [2:0]  drive;
    logic [2:0]  match;
    logic        drive_ch6;
    logic [31:0] word_ch6;
    logic [31:0] word [3];
    logic [4:0]  slot_field [3];
    logic [4:0]  cur_slot;

    // i2s/lj right half maps to slot values 16..31
    assign cur_slot = i2s_mode ? {right_half, slot_cnt[3:0]} : slot_cnt;

    // channel 6 source select, reserved code releases
    always_comb begin
        word_ch6  = 32'h0000_0000;
        drive_ch6 = 1'b0;
        unique case (src_ch6)
            `SSTX_SRC_LOOP: begin
                word_ch6  = link_samples_i.loop_ch2;
                drive_ch6 = 1'b1;
            end
            `SSTX_SRC_ECHO: begin
                word_ch6  = link_samples_i.echo_ch2;
                drive_ch6 = 1'b1;
            end
            default: drive_ch6 = 1'b0;
        endcase
    end

    // channel words: ch7 half-word echo pair, ch8 link stream
    assign word[0] = word_ch6;
    assign word[1] = {link_samples_i.first_echo_half_word,
                      link_samples_i.second_echo_half_word};
    assign word[2] = link_samples_i.inter_chip_link_data;

    // channel enables, zero source releases the line
    assign drive = {src_ch8, (src_ch7 == `SSTX_SRC_ECHO), drive_ch6};

    // one slot comparator per channel
    for (genvar c = 0; c < 3; c++) begin : g_match
        assign slot_field[c] = cfg_link[8*c + `SSTX_SLOT_MSB : 8*c + `SSTX_SLOT_LSB];
        assign match[c]      = drive[c] && (slot_field[c] == cur_slot);
    end

    // pick the channel owning the current slot, drive msb first
    logic        next_dout;
    logic        next_oe;
    logic [4:0]  bit_idx;
    sstx_pin_s   pin_q;

    assign bit_idx = wl_last - bit_cnt;

    // higher channel wins a collision
    always_comb begin
        next_dout = 1'b0;
        next_oe   = 1'b0;
        for (int c = 0; c < 3; c++) begin
            if (match[c]) begin
                next_oe   = 1'b1;
                next_dout = word[c][bit_idx];
            end
        end
    end

    // pin register pair, released outside own slot
    always_ff @(posedge link_bclk_i or negedge link_rst_n_i) begin
        if (!link_rst_n_i) begin
            pin_q.dout    <= 1'b0;
            pin_q.dout_oe <= 1'b0;
        end else begin
            pin_q.dout    <= next_dout;
            pin_q.dout_oe <= next_oe;
        end
    end

    // pins from the carrier
    assign link_dout_o    = pin_q.dout;
    assign link_dout_oe_o = pin_q.dout_oe;

endmodule

// ### verification/sstx_slot_map_checker.sv
`timescale 1ns/10ps
module sstx_slot_map_checker (
    // system and bus
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic [9:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [1:0]  avs_response_o,
    // link side
    input wire logic        link_bclk_i,
    input wire logic        link_rst_n_i,
    input wire logic        link_dout_oe_o
);
    logic req, rd_ok, mapped;
    // ****************
    // helper terms
    // ****************
    assign req = avs_read_i | avs_write_i;
    assign rd_ok = avs_read_i & ~avs_waitrequest_o;
    assign mapped = avs_address_i[9:2] inside {8'h23, 8'h24, 8'h25, 8'h30};
    sequence s_first;
        req && avs_waitrequest_o;
    endsequence
    sequence s_burst;
        link_dout_oe_o [*8];
    endsequence
    AST_WAIT_RISE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(req) |-> avs_waitrequest_o) else $error("no wait state");
    AST_WAIT_ONE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_first |=> !avs_waitrequest_o) else $error("wait too long");
    AST_RD_UPPER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_ok |-> avs_readdata_o[31:8] == 24'h0) else $error("upper bits set");
    AST_RSP_ERR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_ok && !mapped |-> avs_response_o == 2'h2) else $error("no error response");
    AST_RSP_OK: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_ok && mapped |-> avs_response_o == 2'h0) else $error("bad response");
    AST_CH67_RSVD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_ok && avs_address_i[9:2] inside {8'h23, 8'h24} |-> !avs_readdata_o[7])
        else $error("bit 7 set");
    AST_CH8_RSVD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_ok && avs_address_i[9:2] == 8'h25 |-> avs_readdata_o[7:6] == 2'h0)
        else $error("bits 7:6 set");
    AST_OE_MIN: assert property (@(posedge link_bclk_i) disable iff (!link_rst_n_i)
        $rose(link_dout_oe_o) |-> s_burst) else $error("slot too short");
    AST_OE_RST: assert property (@(posedge link_bclk_i) disable iff (!link_rst_n_i)
        $rose(link_rst_n_i) |-> !link_dout_oe_o [*2]) else $error("driving after reset");
endmodule
bind sstx_slot_map sstx_slot_map_checker chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o), .link_bclk_i(link_bclk_i),
    .link_rst_n_i(link_rst_n_i), .link_dout_oe_o(link_dout_oe_o));

// ### verification/sstx_link_host.sv
`timescale 1ns/10ps
module sstx_link_host (
    // link
    input  wire logic          link_bclk_i,
    input  wire logic          link_dout_i,
    input  wire logic          link_dout_oe_i,
    output logic               link_fsync_o,
    output sstx_pkg::sstx_samples_s link_samples_o
);
    import sstx_pkg::*;
    int unsigned cnt = 0;
    int unsigned starts[$];
    logic [31:0] words[$];
    logic [31:0] sh = 32'h0;
    logic        prev_oe = 1'b0;
    initial link_fsync_o = 1'b0;
    // distinct fixed samples per source
    assign link_samples_o = {32'h1357_9bdf, 32'h2468_ace0, 16'hc3a5, 16'h5a3c, 32'hf0e1_d2c3};
    // capture each driven burst msb first; frame of 1024 bits, high half first
    always @(posedge link_bclk_i) begin
        if (link_dout_oe_i && !prev_oe) begin
            starts.push_back(cnt);
        end
        if (link_dout_oe_i) begin
            sh = {sh[30:0], link_dout_i};
        end
        if (!link_dout_oe_i && prev_oe) begin
            words.push_back(sh);
        end
        prev_oe = link_dout_oe_i;
        cnt = (cnt + 1) % 1024;
        link_fsync_o <= (cnt < 512);
    end
endmodule

// ### verification/secondary_serial_tx_slot_map_tb_top.sv
`timescale 1ns/10ps
module secondary_serial_tx_slot_map_tb_top;
    import sstx_pkg::*;
    logic          sys_clk_i = 1'b0;
    logic          link_bclk_i = 1'b0;
    logic          rst_n_i = 1'b0;
    logic [9:0]    avs_address_i = 10'h0;
    logic          avs_read_i = 1'b0;
    logic          avs_write_i = 1'b0;
    logic [31:0]   avs_writedata_i = 32'h0;
    logic [31:0]   avs_readdata_o, rd;
    logic          avs_waitrequest_o, link_fsync_i, link_dout_o, link_dout_oe_o;
    logic [1:0]    avs_response_o, rsp;
    sstx_samples_s smp;
    int            miscompares = 0;
    int            checks = 0;
    // ****************
    // clocks and instances
    // ****************
    always #12.5 sys_clk_i = ~sys_clk_i;
    initial begin
        #3;
        forever #15 link_bclk_i = ~link_bclk_i;
    end
    sstx_slot_map uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(4'h1),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
        .link_bclk_i(link_bclk_i), .link_rst_n_i(rst_n_i), .link_fsync_i(link_fsync_i),
        .link_samples_i(smp), .link_dout_o(link_dout_o), .link_dout_oe_o(link_dout_oe_o));
    sstx_link_host host (.link_bclk_i(link_bclk_i), .link_dout_i(link_dout_o),
        .link_dout_oe_i(link_dout_oe_o), .link_fsync_o(link_fsync_i), .link_samples_o(smp));
    // ****************
    // bus, compare and frame helpers
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        avs_address_i <= {idx, 2'b00};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= {24'h0, wd};
        // hold until waitrequest is sampled low at a rising edge
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n == 50) miscompares++;
        rd = avs_readdata_o;
        rsp = avs_response_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic frame();
        repeat (2) @(posedge link_fsync_i);
        repeat (8) @(posedge link_bclk_i);
        #1 host.starts.delete();
        host.words.delete();
        @(posedge link_fsync_i);
        repeat (8) @(posedge link_bclk_i);
        #1;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_regs();
        bus(0, 8'h23, 8'h0); chk(rd, 32'h05);
        bus(0, 8'h24, 8'h0); chk(rd, 32'h06);
        bus(0, 8'h25, 8'h0); chk(rd, 32'h07);
        frame(); chk(host.starts.size(), 32'h0);
        bus(1, 8'h23, 8'h7f); bus(0, 8'h23, 8'h0); chk(rd, 32'h7f);
        bus(1, 8'h25, 8'h3f); bus(0, 8'h25, 8'h0); chk(rd, 32'h3f);
        bus(0, 8'h40, 8'h0); chk(rsp, 32'h2);
        $display("regs done");
    endtask
    task automatic t_tdm();
        bus(1, 8'h30, 8'h06); bus(1, 8'h23, 8'h22);
        bus(1, 8'h24, 8'h49); bus(1, 8'h25, 8'h3f);
        frame(); chk(host.words.size(), 32'h3);
        chk(host.words[0], smp.loop_ch2);
        chk(host.words[1], {smp.first_echo_half_word, smp.second_echo_half_word});
        chk(host.words[2], smp.inter_chip_link_data);
        chk(host.starts[1] - host.starts[0], 32'he0);
        chk(host.starts[2] - host.starts[0], 32'h3a0);
        $display("tdm done");
    endtask
    task automatic t_i2s();
        bus(1, 8'h30, 8'h07); bus(1, 8'h23, 8'h50);
        bus(1, 8'h24, 8'h00); bus(1, 8'h25, 8'h21);
        frame(); chk(host.words.size(), 32'h2);
        chk(host.words[0], smp.inter_chip_link_data);
        chk(host.words[1], smp.echo_ch2);
        chk(host.starts[1] - host.starts[0], 32'h1e0);
        bus(1, 8'h23, 8'h62); bus(1, 8'h24, 8'h29); bus(1, 8'h25, 8'h1f);
        frame(); chk(host.starts.size(), 32'h0);
        $display("i2s done");
    endtask
    task automatic final_report();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // main sequence and watchdog
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_tdm();
        t_i2s();
        final_report();
    end
    initial begin
        #2000000;
        miscompares++;
        final_report();
    end
endmodule
